/* src/pme_memory_extender.sv */
// The address map and the Avalon-MM interface to the registers were left to the implementer.
module pme_memory_extender
  import pme_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Avalon-MM slave
  input wire logic [pme_pkg::PME_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [1:0] avs_response,
  // Processor core
  input wire pme_pkg::pme_cpu_t cpu_in,
  output pme_pkg::pme_xlat_t xlat_out,
  output logic [7:0] page_to_stack,
  // Extended flash port
  output pme_pkg::pme_mem_req_t mem_req,
  input wire logic mem_ack,
  input wire logic [7:0] mem_rdata
);
  import pme_pkg::*;

  // ==========================================================================
  // Registers
  logic [7:0] page_q;
  logic [15:0] ptr_q;
  logic [15:0] ptr_d;
  pme_state_t state_q;
  logic [7:0] rdata_q;
  logic [1:0] resp_q;
  logic [3:0] word_idx;
  logic is_data_port;
  logic is_incr_port;
  logic lane0;
  logic [15:0] add_ext;
  logic hit_word_incr;
  logic hit_byte_incr;
  logic hit_plain;
  logic bus_req;
  logic idle_req;
  logic reg_wr;
  logic in_window;

  // ==========================================================================
  // Bus decode
  assign word_idx = avs_address[PME_ADDR_W-1:2];
  assign lane0 = avs_byteenable[0];
  assign bus_req = avs_read || avs_write;
  assign idle_req = (state_q == PME_IDLE) && bus_req;
  assign reg_wr = (state_q == PME_IDLE) && avs_write && lane0;
  assign hit_word_incr = word_idx == PME_OFF_WORD_INCR;
  assign hit_byte_incr = word_idx == PME_OFF_BYTE_INCR;
  assign hit_plain = word_idx == PME_OFF_PLAIN;
  assign is_data_port = hit_plain || hit_byte_incr || hit_word_incr;
  assign is_incr_port = hit_byte_incr || hit_word_incr;
  assign add_ext = {{8{avs_writedata[7]}}, avs_writedata[7:0]};

  // ==========================================================================
  // Bus sequencing
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      state_q <= PME_IDLE;
    end
    else
    begin
      unique case (state_q)
        PME_IDLE:
        begin
          if (bus_req && is_data_port)
          begin
            state_q <= PME_WAIT;
          end
          else if (bus_req)
          begin
            state_q <= PME_DONE;
          end
        end
        PME_WAIT:
        begin
          if (mem_ack)
          begin
            state_q <= PME_DONE;
          end
        end
        PME_DONE:
        begin
          state_q <= PME_IDLE;
        end
        default:
        begin
          state_q <= PME_IDLE;
        end
      endcase
    end
  end

  assign avs_waitrequest = bus_req && (state_q != PME_DONE);
  assign avs_readdata = {24'h000000, rdata_q};
  assign avs_response = resp_q;

  // ==========================================================================
  // Flash request
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      mem_req <= '0;
    end
    else if (idle_req && is_data_port)
    begin
      mem_req.req <= 1'b1;
      mem_req.wr <= avs_write && lane0;
      mem_req.addr <= ptr_q;
      mem_req.wdata <= avs_writedata[7:0];
    end
    else if (mem_ack)
    begin
      mem_req.req <= 1'b0;
    end
  end

  // ==========================================================================
  // Read data
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      rdata_q <= 8'h00;
    end
    else if (state_q == PME_WAIT && mem_ack)
    begin
      rdata_q <= mem_req.wr ? 8'h00 : mem_rdata;
    end
    else if (idle_req && !is_data_port)
    begin
      unique case (word_idx)
        PME_OFF_PAGE:
        begin
          rdata_q <= page_q;
        end
        PME_OFF_PTR_HI:
        begin
          rdata_q <= ptr_q[15:8];
        end
        PME_OFF_PTR_LO:
        begin
          rdata_q <= ptr_q[7:0];
        end
        PME_OFF_PTR_ADD:
        begin
          rdata_q <= 8'h00;
        end
        default:
        begin
          rdata_q <= 8'h00;
        end
      endcase
    end
  end

  // ==========================================================================
  // Response code
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      resp_q <= 2'h0;
    end
    else if (state_q == PME_WAIT && mem_ack)
    begin
      resp_q <= 2'h0;
    end
    else if (idle_req && !is_data_port)
    begin
      unique case (word_idx)
        PME_OFF_PAGE,
        PME_OFF_PTR_HI,
        PME_OFF_PTR_LO,
        PME_OFF_PTR_ADD:
        begin
          resp_q <= 2'h0;
        end
        default:
        begin
          resp_q <= 2'h2;
        end
      endcase
    end
  end

  // ==========================================================================
  // Page select
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      page_q <= PME_PAGE_RST;
    end
    else if (cpu_in.far_load)
    begin
      page_q <= cpu_in.far_page;
    end
    else if (reg_wr && word_idx == PME_OFF_PAGE)
    begin
      page_q <= avs_writedata[7:0];
    end
  end

  // ==========================================================================
  // Page to stack
  assign page_to_stack = page_q;

  // ==========================================================================
  // Linear pointer
  always_comb
  begin
    ptr_d = ptr_q;
    if (state_q == PME_WAIT && mem_ack && is_incr_port)
    begin
      ptr_d = ptr_q + 16'h0001;
    end
    else if (reg_wr)
    begin
      unique case (word_idx)
        PME_OFF_PTR_HI:
        begin
          ptr_d = {avs_writedata[7:0], ptr_q[7:0]};
        end
        PME_OFF_PTR_LO:
        begin
          ptr_d = {ptr_q[15:8], avs_writedata[7:0]};
        end
        PME_OFF_PTR_ADD:
        begin
          ptr_d = ptr_q + add_ext;
        end
        default:
        begin
          ptr_d = ptr_q;
        end
      endcase
    end
  end

  // ==========================================================================
  // Pointer register
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      ptr_q <= PME_PTR_RST;
    end
    else
    begin
      ptr_q <= ptr_d;
    end
  end

  // ==========================================================================
  // Program window translation
  assign in_window = cpu_in.addr[15:PME_WIN_LSB] == PME_WIN_TAG;

  always_comb
  begin
    if (in_window)
    begin
      xlat_out.paged = 1'b1;
      xlat_out.ext_addr = {page_q[2:0], cpu_in.addr[PME_WIN_LSB-1:0]};
    end
    else
    begin
      xlat_out.paged = 1'b0;
      xlat_out.ext_addr = {1'b0, cpu_in.addr};
    end
  end

endmodule // pme_memory_extender

/* src/pme_pkg.sv */
package pme_pkg;

  // ==========================================================================
  // Register word offsets (word indices, taken from Avalon address bits [5:2])
  localparam logic [3:0] PME_OFF_PAGE = 4'h0;
  localparam logic [3:0] PME_OFF_PTR_HI = 4'h1;
  localparam logic [3:0] PME_OFF_PTR_LO = 4'h2;
  localparam logic [3:0] PME_OFF_WORD_INCR = 4'h3;
  localparam logic [3:0] PME_OFF_BYTE_INCR = 4'h4;
  localparam logic [3:0] PME_OFF_PLAIN = 4'h5;
  localparam logic [3:0] PME_OFF_PTR_ADD = 4'h6;
  localparam int PME_ADDR_W = 6;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] PME_PAGE_RST = 8'h02;
  localparam logic [15:0] PME_PTR_RST = 16'h0000;

  // ==========================================================================
  // Program window decode
  localparam logic [1:0] PME_WIN_TAG = 2'h2;
  localparam int PME_WIN_LSB = 14;
  localparam int PME_EXT_W = 17;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic [15:0] addr;
    logic far_load;
    logic [7:0] far_page;
  } pme_cpu_t;

  typedef struct packed {
    logic [PME_EXT_W-1:0] ext_addr;
    logic paged;
  } pme_xlat_t;

  typedef struct packed {
    logic req;
    logic wr;
    logic [15:0] addr;
    logic [7:0] wdata;
  } pme_mem_req_t;

  typedef enum logic [1:0] {
    PME_IDLE,
    PME_WAIT,
    PME_DONE
  } pme_state_t;

endpackage

/* tb/pme_memory_extender_props.sv */
module pme_memory_extender_props
  import pme_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Bus
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Core and flash
  input wire pme_pkg::pme_cpu_t cpu_in,
  input wire pme_pkg::pme_xlat_t xlat_out,
  input wire logic [7:0] page_to_stack,
  input wire pme_pkg::pme_mem_req_t mem_req,
  input wire logic mem_ack,
  input wire logic [7:0] mem_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking dc @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic win;
  assign win = cpu_in.addr[15:14] == PME_WIN_TAG;
  win_map_a: assert property (win |-> xlat_out == {page_to_stack[2:0], cpu_in.addr[13:0], 1'b1})
    else $error("bad map");
  pass_map_a: assert property (!win |-> xlat_out == {1'b0, cpu_in.addr, 1'b0})
    else $error("bad pass");
  page_rst_a: assert property ($past(rst) |-> page_to_stack == PME_PAGE_RST)
    else $error("bad page reset");
  far_load_a: assert property (cpu_in.far_load |=> page_to_stack == $past(cpu_in.far_page))
    else $error("bad far load");
  req_hold_a: assert property (mem_req.req && !mem_ack |=> mem_req.req && $stable(mem_req.addr))
    else $error("req dropped");
  hi_zero_a: assert property (avs_readdata[31:8] == 24'h0)
    else $error("upper bits set");
  ack_done_a: assert property (mem_ack |=> !avs_waitrequest)
    else $error("no answer");
  rd_data_a: assert property (mem_ack && !mem_req.wr |=> avs_readdata[7:0] == $past(mem_rdata))
    else $error("bad read data");
  cover property (mem_ack && mem_req.wr);
  cover property (cpu_in.far_load);
  cover property (xlat_out.paged);
endmodule // pme_memory_extender_props

/* tb/pme_flash_model.sv */
module pme_flash_model
  import pme_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire pme_pkg::pme_mem_req_t mem_req,
  output logic mem_ack,
  output logic [7:0] mem_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [256];
  logic [1:0] cnt_q;
  initial
  begin
    for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5A;
  end
  // Odd addresses answer slowly, even ones at once; data toggles when idle
  always @(posedge clk_sys)
  begin
    mem_ack <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (rst)
    begin
      cnt_q <= 2'h0;
      mem_rdata <= 8'h00;
    end
    else if (mem_req.req && !mem_ack)
    begin
      if (cnt_q >= {2{mem_req.addr[0]}})
      begin
        mem_ack <= 1'b1;
        mem_rdata <= mem[mem_req.addr[7:0]];
        cnt_q <= 2'h0;
        if (mem_req.wr) mem[mem_req.addr[7:0]] <= mem_req.wdata;
      end
      else cnt_q <= cnt_q + 2'h1;
    end
  end
endmodule // pme_flash_model

/* tb/paged_and_linear_memory_extender_tb_top.sv */
module paged_and_linear_memory_extender_tb_top;
  import pme_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 0;
  logic rst = 1;
  logic [5:0] avs_address = '0;
  logic avs_read = 0;
  logic avs_write = 0;
  logic [31:0] avs_writedata = '0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic mem_ack;
  logic [1:0] avs_response;
  logic [1:0] rsp;
  pme_cpu_t cpu_in = '0;
  pme_xlat_t xlat_out;
  pme_mem_req_t mem_req;
  logic [7:0] page_to_stack;
  logic [7:0] mem_rdata;
  logic [7:0] q;
  logic [15:0] p;
  logic [7:0] adds [3] = '{8'h7F, 8'hFF, 8'h80};
  int bad_count = 0;
  int compares = 0;
  initial forever #20 clk_sys = ~clk_sys;
  pme_memory_extender DUT (.clk_sys(clk_sys), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .avs_response(avs_response), .cpu_in(cpu_in), .xlat_out(xlat_out),
    .page_to_stack(page_to_stack), .mem_req(mem_req), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
  pme_flash_model u_flash (.clk_sys(clk_sys), .rst(rst), .mem_req(mem_req), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata));
  task chk(input logic [17:0] seen, input logic [17:0] exp);
    compares++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("FAIL %0t saw %h want %h", $time, seen, exp);
    end
  endtask
  task acc(input logic w, input logic [3:0] a, input logic [7:0] d);
    int n;
    @(posedge clk_sys);
    avs_address <= {a, 2'h0};
    avs_read <= !w;
    avs_write <= w;
    avs_writedata <= {24'h0, d};
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 200);
    if (n >= 200) bad_count++;
    q = avs_readdata[7:0];
    rsp = avs_response;
    avs_read <= 0;
    avs_write <= 0;
  endtask
  task rd(input logic [3:0] a, input logic [7:0] e);
    acc(0, a, 8'h00);
    chk(q, e);
  endtask
  task stop_test;
    $display("bad %0d compares %0d", bad_count, compares);
    if (bad_count == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    bad_count++;
    stop_test;
  end
  initial
  begin
    repeat (10) @(posedge clk_sys);
    rst <= 0;
    rd(PME_OFF_PAGE, 8'h02);
    rd(PME_OFF_PTR_HI, 8'h00);
    rd(PME_OFF_PTR_LO, 8'h00);
    @(posedge clk_sys);
    cpu_in.addr <= 16'h8123;
    @(negedge clk_sys);
    chk(xlat_out, {3'h2, 14'h0123, 1'b1});
    @(posedge clk_sys);
    cpu_in <= '{16'h4123, 1'b1, 8'h07};
    @(posedge clk_sys);
    cpu_in.far_load <= 0;
    @(negedge clk_sys);
    chk(page_to_stack, 8'h07);
    chk(xlat_out, {1'b0, 16'h4123, 1'b0});
    acc(1, PME_OFF_PAGE, 8'h05);
    rd(PME_OFF_PAGE, 8'h05);
    acc(1, PME_OFF_PTR_HI, 8'h12);
    acc(1, PME_OFF_PTR_LO, 8'hFF);
    rd(PME_OFF_PLAIN, 8'hA5);
    rd(PME_OFF_PTR_LO, 8'hFF);
    rd(PME_OFF_WORD_INCR, 8'hA5);
    rd(PME_OFF_BYTE_INCR, 8'h5A);
    rd(PME_OFF_PTR_HI, 8'h13);
    acc(1, PME_OFF_PLAIN, 8'hC3);
    rd(PME_OFF_PLAIN, 8'hC3);
    acc(1, PME_OFF_BYTE_INCR, 8'h3C);
    rd(PME_OFF_PTR_LO, 8'h02);
    acc(1, PME_OFF_PTR_LO, 8'h01);
    rd(PME_OFF_PLAIN, 8'h3C);
    p = 16'h1301;
    foreach (adds[i])
    begin
      acc(1, PME_OFF_PTR_ADD, adds[i]);
      p = p + {{8{adds[i][7]}}, adds[i]};
      rd(PME_OFF_PTR_HI, p[15:8]);
      rd(PME_OFF_PTR_LO, p[7:0]);
    end
    rd(4'h7, 8'h00);
    chk(rsp, 2'h2);
    stop_test;
  end
endmodule // paged_and_linear_memory_extender_tb_top
bind pme_memory_extender pme_memory_extender_props u_props (.clk_sys(clk_sys), .rst(rst),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .cpu_in(cpu_in), .xlat_out(xlat_out),
  .page_to_stack(page_to_stack), .mem_req(mem_req), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
